// ### shared/ddc_pkg.sv
// constants and types shared by the frequency translation stage
package ddc_pkg;

  typedef logic [11:0] ddc_addr_t;
  typedef logic [7:0] ddc_byte_t;
  typedef logic signed [15:0] ddc_sample_t;
  typedef logic [47:0] ddc_word48_t;

  // translation modes, field of the channel control register
  typedef enum logic [1:0]
  {
    DDC_MODE_VARIABLE = 2'h0,
    DDC_MODE_ZERO_IF = 2'h1,
    DDC_MODE_FS4 = 2'h2,
    DDC_MODE_TEST = 2'h3
  } ddc_mode_t;

  localparam int DDC_CHANNELS = 2;
  localparam int DDC_PHASE_BITS = 48;

  // register map
  localparam ddc_addr_t DDC_ADDR_PAIR_SEL = 12'h009;
  localparam ddc_addr_t DDC_ADDR_FSYNC0 = 12'h120;
  localparam ddc_addr_t DDC_ADDR_FSYNC1 = 12'h121;
  localparam ddc_addr_t DDC_ADDR_SYNC_CTRL = 12'h300;
  localparam ddc_addr_t DDC_ADDR_CH0_CTRL = 12'h310;
  localparam ddc_addr_t DDC_ADDR_CH1_CTRL = 12'h330;
  localparam ddc_addr_t DDC_OFF_TUNING = 12'h006;
  localparam ddc_addr_t DDC_OFF_PHASE = 12'h00D;
  localparam int DDC_WORD_BYTES = 6;

  // reset values
  localparam ddc_byte_t DDC_RST_BYTE = 8'h00;
  localparam ddc_word48_t DDC_RST_WORD = 48'h0000_0000_0000;

  // field positions
  localparam int DDC_CTRL_CPLX_BIT = 7;
  localparam int DDC_CTRL_MODE_LSB = 4;
  localparam int DDC_SYNC_SOFT_BIT = 4;
  localparam int DDC_SYNC_EN_LSB = 0;
  localparam int DDC_FSYNC_EN_BIT = 0;
  localparam int DDC_PAIR_EN_BIT = 0;

  // amplitudes: oscillator peak carries 0.05 dB loss, test level is 0.9599 full scale
  localparam ddc_sample_t DDC_OSC_PEAK = 16'h7F43;
  localparam ddc_sample_t DDC_TEST_LEVEL = 16'h7ADD;
  localparam logic signed [16:0] DDC_CPLX_SCALE = 17'h05A03;
  localparam int DDC_REAL_SHIFT = 16;
  localparam int DDC_Q15_SHIFT = 15;

  // quarter sine, 17 points, peak already scaled
  localparam logic [16:0][15:0] DDC_QSIN = {
    16'h7F43, 16'h7EA6, 16'h7CD1, 16'h79C7, 16'h7593, 16'h703B, 16'h69D0, 16'h6260, 16'h59FC,
    16'h50BC, 16'h46B4, 16'h3BFE, 16'h30B3, 16'h24F1, 16'h18D4, 16'h0C7C, 16'h0000};

  // buffer
  localparam int DDC_BUF_WIDTH = 64;

endpackage

// ### rtl/ddc_skid_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ddc_skid_buf
#(
  parameter int WIDTH = 64
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [WIDTH-1:0] push_data,
  output logic pop_valid,
  input wire logic pop_ready,
  output logic [WIDTH-1:0] pop_data
);

  logic [1:0] count_q;
  logic [1:0] count_d;
  logic [WIDTH-1:0] spare_q;
  logic do_push;
  logic do_pop;

  assign do_push = push_valid && push_ready;
  assign do_pop = pop_valid && pop_ready;

  always_comb
  begin
    count_d = count_q;
    if (do_push && !do_pop)
    begin
      count_d = count_q + 2'h1;
    end
    else if (do_pop && !do_push)
    begin
      count_d = count_q - 2'h1;
    end
  end

  // flags are flops so both handshakes leave straight from registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= 2'h0;
      push_ready <= 1'b0;
      pop_valid <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      push_ready <= (count_d != 2'h2);
      pop_valid <= (count_d != 2'h0);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pop_data <= '0;
      spare_q <= '0;
    end
    else
    begin
      if (do_pop)
      begin
        pop_data <= (count_q == 2'h2) ? spare_q : push_data;
        if (count_q == 2'h2 && do_push)
        begin
          spare_q <= push_data;
        end
      end
      else if (do_push)
      begin
        if (count_q == 2'h0)
        begin
          pop_data <= push_data;
        end
        else
        begin
          spare_q <= push_data;
        end
      end
    end
  end

endmodule

// ### rtl/ddc_translate.sv
// oscillator, quadrature mixer and control registers of the translation stage
//
// Contract
// RL1: each channel shifts its input to complex baseband with a 48-bit oscillator and mixer
// RL2: control bits 5:4 pick one of four translation modes per channel
// RL3: variable mode runs oscillator and mixer at the programmed tuning frequency
// RL4: zero-IF mode bypasses the mixer and stops the oscillator
// RL5: fs/4 mode mixes with a fixed quarter-rate carrier
// RL6: test mode replaces input with 0.9599 full scale, oscillator running
// RL7: real input mixed to baseband loses 6 dB plus 0.05 dB
// RL8: complex mixer scales I and Q down 3.06 dB, total 3.11 dB
// RL9: software should enable the later 6 dB gain for real input
// RL10: tuning word is 48-bit two's complement of scaled carrier over sample rate
// RL11: tuning word spans minus half rate up to just below plus half rate
// RL12: software rounds to nearest and keeps the dividend sign in the remainder
// RL13: carrier equals tuning word times sample rate over 2 to the 48
// RL14: each oscillator has its own 48-bit phase offset word
// RL15: software writes tuning words, then phase offsets, then synchronises
// RL16: accumulator starts at zero, steps by tuning word, phase adds the offset
// RL17: soft reset bit high then low clears all accumulators of the pair
// RL18: enabled frame sync events clear all accumulators
// RL19: real input uses two products, complex input a full complex multiply
// RL20: control bit 7 selects real or complex input per channel
// RL21: channel register accesses are steered by the pair select register
// RL22: accumulator steps once per sample, wraps, and holds zero during sync
`timescale 1ns/1ps
module ddc_translate
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ddc_pkg::ddc_addr_t reg_addr,
  input wire logic reg_wr,
  input wire ddc_pkg::ddc_byte_t reg_wdata,
  input wire logic reg_rd,
  output ddc_pkg::ddc_byte_t reg_rdata,
  input wire logic frame_sync,
  input wire logic in_valid,
  output logic in_ready,
  input wire ddc_pkg::ddc_sample_t in_i,
  input wire ddc_pkg::ddc_sample_t in_q,
  output logic out_valid,
  input wire logic out_ready,
  output ddc_pkg::ddc_sample_t out0_i,
  output ddc_pkg::ddc_sample_t out0_q,
  output ddc_pkg::ddc_sample_t out1_i,
  output ddc_pkg::ddc_sample_t out1_q
);

  import ddc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic ddc_addr_t chan_base(input int ch);
    chan_base = (ch == 0) ? DDC_ADDR_CH0_CTRL : DDC_ADDR_CH1_CTRL;
  endfunction

  // byte k of a 48-bit word placed at base + off
  function automatic logic byte_hit(input ddc_addr_t addr, input ddc_addr_t base, input ddc_addr_t off,
                                    input int k);
    byte_hit = (addr == base + off + 12'(k));
  endfunction

  // quarter-table sine of a 6-bit phase
  function automatic ddc_sample_t sine6(input logic [5:0] ph);
    logic [4:0] idx;
    ddc_sample_t mag;
    idx = ph[4] ? (5'h10 - {1'b0, ph[3:0]}) : {1'b0, ph[3:0]};
    mag = DDC_QSIN[idx];
    sine6 = ph[5] ? -mag : mag;
  endfunction

  // downconversion by e^-jwt, returns {i, q}
  function automatic logic [31:0] mix(input ddc_sample_t xi, input ddc_sample_t xq,
                                      input ddc_sample_t c, input ddc_sample_t s, input logic cplx);
    logic signed [32:0] acc_i;
    logic signed [32:0] acc_q;
    logic signed [33:0] sc_i;
    logic signed [33:0] sc_q;
    logic signed [49:0] fin_i;
    logic signed [49:0] fin_q;
    acc_i = '0;
    acc_q = '0;
    fin_i = '0;
    fin_q = '0;
    if (cplx)
    begin
      // four products and two sums
      // operands widened first so no product is cut to sample width
      acc_i = 33'(xi) * 33'(c) + 33'(xq) * 33'(s); // RL19
      acc_q = 33'(xq) * 33'(c) - 33'(xi) * 33'(s); // RL19
      sc_i = 34'(acc_i >>> DDC_Q15_SHIFT);
      sc_q = 34'(acc_q >>> DDC_Q15_SHIFT);
      // 3.06 dB keeps the 1.414 peak in range and widths as for real mixing
      fin_i = 50'(sc_i) * 50'(DDC_CPLX_SCALE) >>> DDC_Q15_SHIFT; // RL8
      fin_q = 50'(sc_q) * 50'(DDC_CPLX_SCALE) >>> DDC_Q15_SHIFT; // RL8
    end
    else
    begin
      // two products, image loss of 6 dB applied as one extra bit of shift
      fin_i = 50'(xi) * 50'(c) >>> DDC_REAL_SHIFT; // RL19 RL7
      fin_q = -(50'(xi) * 50'(s) >>> DDC_REAL_SHIFT); // RL19 RL7
    end
    mix = {fin_i[15:0], fin_q[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  ddc_byte_t pair_sel_q;
  ddc_byte_t fsync0_q;
  ddc_byte_t fsync1_q;
  ddc_byte_t sync_ctrl_q;
  ddc_byte_t ctrl_q [DDC_CHANNELS];
  ddc_word48_t tuning_word_value_q [DDC_CHANNELS];
  ddc_word48_t phase_offset_word_q [DDC_CHANNELS];
  logic pair_open;

  // channel registers only answer while this pair is selected
  assign pair_open = pair_sel_q[DDC_PAIR_EN_BIT]; // RL21

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pair_sel_q <= DDC_RST_BYTE;
      fsync0_q <= DDC_RST_BYTE;
      fsync1_q <= DDC_RST_BYTE;
      sync_ctrl_q <= DDC_RST_BYTE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        DDC_ADDR_PAIR_SEL: pair_sel_q <= reg_wdata;
        DDC_ADDR_FSYNC0: fsync0_q <= reg_wdata;
        DDC_ADDR_FSYNC1: fsync1_q <= reg_wdata;
        DDC_ADDR_SYNC_CTRL: sync_ctrl_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int ch = 0; ch < DDC_CHANNELS; ch++)
      begin
        ctrl_q[ch] <= DDC_RST_BYTE;
        tuning_word_value_q[ch] <= DDC_RST_WORD;
        phase_offset_word_q[ch] <= DDC_RST_WORD;
      end
    end
    else if (reg_wr && pair_open) // RL21
    begin
      for (int ch = 0; ch < DDC_CHANNELS; ch++)
      begin
        if (reg_addr == chan_base(ch))
        begin
          ctrl_q[ch] <= reg_wdata; // RL2 RL20
        end
        for (int k = 0; k < DDC_WORD_BYTES; k++)
        begin
          if (byte_hit(reg_addr, chan_base(ch), DDC_OFF_TUNING, k))
          begin
            tuning_word_value_q[ch][8*k +: 8] <= reg_wdata; // RL10
          end
          if (byte_hit(reg_addr, chan_base(ch), DDC_OFF_PHASE, k))
          begin
            phase_offset_word_q[ch][8*k +: 8] <= reg_wdata; // RL14
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= DDC_RST_BYTE;
    end
    else if (reg_rd)
    begin
      // unmapped and closed channel addresses read as zero
      case (reg_addr)
        DDC_ADDR_PAIR_SEL: reg_rdata <= pair_sel_q;
        DDC_ADDR_FSYNC0: reg_rdata <= fsync0_q;
        DDC_ADDR_FSYNC1: reg_rdata <= fsync1_q;
        DDC_ADDR_SYNC_CTRL: reg_rdata <= sync_ctrl_q;
        default: reg_rdata <= DDC_RST_BYTE;
      endcase
      for (int ch = 0; ch < DDC_CHANNELS; ch++)
      begin
        if (pair_open && reg_addr == chan_base(ch)) // RL21
        begin
          reg_rdata <= ctrl_q[ch];
        end
        for (int k = 0; k < DDC_WORD_BYTES; k++)
        begin
          if (pair_open && byte_hit(reg_addr, chan_base(ch), DDC_OFF_TUNING, k))
          begin
            reg_rdata <= tuning_word_value_q[ch][8*k +: 8];
          end
          if (pair_open && byte_hit(reg_addr, chan_base(ch), DDC_OFF_PHASE, k))
          begin
            reg_rdata <= phase_offset_word_q[ch][8*k +: 8];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisation

  logic frame_sync_prev_q;
  logic frame_sync_event;
  logic soft_hold;
  logic acc_clear;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_sync_prev_q <= 1'b0;
    end
    else
    begin
      frame_sync_prev_q <= frame_sync;
    end
  end

  // event counts only with both the pin and the downconverter sync enabled
  assign frame_sync_event = frame_sync && !frame_sync_prev_q && fsync0_q[DDC_FSYNC_EN_BIT]
                            && (sync_ctrl_q[DDC_SYNC_EN_LSB +: 2] != 2'h0); // RL18
  // accumulators stay cleared for as long as the soft bit is high
  assign soft_hold = sync_ctrl_q[DDC_SYNC_SOFT_BIT]; // RL17
  assign acc_clear = soft_hold || frame_sync_event; // RL22

  ////////////////////////////////////////////////////////////////////////////
  // oscillators

  logic take;
  ddc_word48_t phase_accumulator_q [DDC_CHANNELS];
  logic [1:0] quarter_q [DDC_CHANNELS];
  ddc_mode_t mode [DDC_CHANNELS];

  assign take = in_valid && in_ready;

  always_comb
  begin
    for (int ch = 0; ch < DDC_CHANNELS; ch++)
    begin
      mode[ch] = ddc_mode_t'(ctrl_q[ch][DDC_CTRL_MODE_LSB +: 2]); // RL2
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int ch = 0; ch < DDC_CHANNELS; ch++)
      begin
        phase_accumulator_q[ch] <= DDC_RST_WORD; // RL16
        quarter_q[ch] <= 2'h0;
      end
    end
    else
    begin
      for (int ch = 0; ch < DDC_CHANNELS; ch++)
      begin
        if (acc_clear || mode[ch] == DDC_MODE_ZERO_IF) // RL22 RL4
        begin
          phase_accumulator_q[ch] <= DDC_RST_WORD;
          quarter_q[ch] <= 2'h0;
        end
        else if (take)
        begin
          // wraps modulo 2^48, so a two's complement word tunes below dc too
          phase_accumulator_q[ch] <= phase_accumulator_q[ch] + tuning_word_value_q[ch]; // RL16 RL11 RL13 RL22
          quarter_q[ch] <= quarter_q[ch] + 2'h1; // RL5
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mixer

  ddc_word48_t phase [DDC_CHANNELS];
  ddc_sample_t osc_c [DDC_CHANNELS];
  ddc_sample_t osc_s [DDC_CHANNELS];
  ddc_sample_t src_i [DDC_CHANNELS];
  ddc_sample_t src_q [DDC_CHANNELS];
  logic [31:0] mixed [DDC_CHANNELS];

  always_comb
  begin
    for (int ch = 0; ch < DDC_CHANNELS; ch++)
    begin
      phase[ch] = phase_accumulator_q[ch] + phase_offset_word_q[ch]; // RL16 RL14
      osc_s[ch] = sine6(phase[ch][47:42]); // RL1 RL3
      osc_c[ch] = sine6(phase[ch][47:42] + 6'h10); // RL1 RL3
      src_i[ch] = in_i;
      src_q[ch] = in_q;
      mixed[ch] = '0;
      unique case (mode[ch])
        DDC_MODE_VARIABLE:
        begin
          mixed[ch] = mix(src_i[ch], src_q[ch], osc_c[ch], osc_s[ch], ctrl_q[ch][DDC_CTRL_CPLX_BIT]); // RL3 RL20
        end
        DDC_MODE_ZERO_IF:
        begin
          mixed[ch] = {src_i[ch], src_q[ch]}; // RL4
        end
        DDC_MODE_FS4:
        begin
          // carrier walks 0, 90, 180, 270 degrees: no table, no accumulator needed
          osc_c[ch] = quarter_q[ch][0] ? 16'h0000 : (quarter_q[ch][1] ? -DDC_OSC_PEAK : DDC_OSC_PEAK); // RL5
          osc_s[ch] = !quarter_q[ch][0] ? 16'h0000 : (quarter_q[ch][1] ? -DDC_OSC_PEAK : DDC_OSC_PEAK); // RL5
          mixed[ch] = mix(src_i[ch], src_q[ch], osc_c[ch], osc_s[ch], ctrl_q[ch][DDC_CTRL_CPLX_BIT]); // RL20
        end
        DDC_MODE_TEST:
        begin
          src_i[ch] = DDC_TEST_LEVEL; // RL6
          src_q[ch] = DDC_TEST_LEVEL; // RL6
          mixed[ch] = mix(src_i[ch], src_q[ch], osc_c[ch], osc_s[ch], ctrl_q[ch][DDC_CTRL_CPLX_BIT]); // RL6
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output buffer, a stalled receiver backs up into in_ready

  logic [DDC_BUF_WIDTH-1:0] buf_out;

  ddc_skid_buf #(
    .WIDTH(DDC_BUF_WIDTH)
  ) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .push_valid(in_valid),
    .push_ready(in_ready),
    .push_data({mixed[0], mixed[1]}),
    .pop_valid(out_valid),
    .pop_ready(out_ready),
    .pop_data(buf_out)
  );

  assign out0_i = buf_out[63:48];
  assign out0_q = buf_out[47:32];
  assign out1_i = buf_out[31:16];
  assign out1_q = buf_out[15:0];

endmodule

// ### tb/ddc_translate_chk.sv
// port assertions for the frequency translation stage, bound into the design
`timescale 1ns/1ps
module ddc_translate_chk
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ddc_pkg::ddc_addr_t reg_addr,
  input wire logic reg_wr,
  input wire ddc_pkg::ddc_byte_t reg_wdata,
  input wire logic reg_rd,
  input wire ddc_pkg::ddc_byte_t reg_rdata,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire ddc_pkg::ddc_sample_t in_i,
  input wire ddc_pkg::ddc_sample_t in_q,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire ddc_pkg::ddc_sample_t out0_i,
  input wire ddc_pkg::ddc_sample_t out0_q
);
  import ddc_pkg::*;
  localparam ddc_addr_t UNMAPPED = 12'h200;
  logic pair_q, push, pop;
  logic [1:0] mode_q, cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  //////////////////////////////////////////////////////////////////////////////
  // shadow state rebuilt from port traffic only
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) pair_q <= 1'b0;
    else if (reg_wr && reg_addr == DDC_ADDR_PAIR_SEL) pair_q <= reg_wdata[0];
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) mode_q <= 2'h0;
    else if (reg_wr && pair_q && reg_addr == DDC_ADDR_CH0_CTRL) mode_q <= reg_wdata[5:4];
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) cnt_q <= 2'h0;
    else cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_unmapped; reg_rd && reg_addr == UNMAPPED |=> reg_rdata == 8'h00; endproperty
  property p_gate; reg_rd && !pair_q && (reg_addr == DDC_ADDR_CH0_CTRL || reg_addr == DDC_ADDR_CH1_CTRL)
    |=> reg_rdata == 8'h00; endproperty
  property p_pair_rb; reg_rd && reg_addr == DDC_ADDR_PAIR_SEL |=> reg_rdata[0] == $past(pair_q); endproperty
  property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  property p_occ; out_valid == (cnt_q != 2'h0); endproperty
  property p_full; cnt_q == 2'h2 |-> !in_ready; endproperty
  property p_refill; cnt_q == 2'h2 && out_ready |=> in_ready && out_valid; endproperty
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out0_i) && $stable(out0_q); endproperty
  property p_zif; mode_q == DDC_MODE_ZERO_IF && push && cnt_q == 2'h0
    |=> out0_i == $past(in_i) && out0_q == $past(in_q); endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_gate: assert property (p_gate) else $error("channel register open without pair select");
  a_pair_rb: assert property (p_pair_rb) else $error("pair select readback wrong");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  a_occ: assert property (p_occ) else $error("out_valid disagrees with occupancy");
  a_full: assert property (p_full) else $error("in_ready high with two entries");
  a_refill: assert property (p_refill) else $error("no room after pop from full buffer");
  a_hold: assert property (p_hold) else $error("stalled output changed");
  a_zif: assert property (p_zif) else $error("zero-IF output differs from input");
  c_full: cover property (cnt_q == 2'h2 && out_ready);
  c_zif: cover property (mode_q == DDC_MODE_ZERO_IF && push);
  c_gate: cover property (reg_rd && !pair_q && reg_addr == DDC_ADDR_CH0_CTRL);
endmodule

bind ddc_translate ddc_translate_chk chk (.*);

// ### tb/ddc_stream_model.sv
// converter sample source and downstream filter sink facing the translation stage
`timescale 1ns/1ps
module ddc_stream_model
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic stall,
  output logic in_valid,
  input wire logic in_ready,
  output ddc_pkg::ddc_sample_t in_i,
  output ddc_pkg::ddc_sample_t in_q,
  input wire logic out_valid,
  output logic out_ready,
  input wire ddc_pkg::ddc_sample_t out0_i,
  input wire ddc_pkg::ddc_sample_t out0_q,
  input wire ddc_pkg::ddc_sample_t out1_i,
  input wire ddc_pkg::ddc_sample_t out1_q
);
  import ddc_pkg::*;
  logic [31:0] tx[$];
  logic [63:0] rx[$];
  logic took = 1'b0;
  initial
  begin
    in_valid = 1'b0;
    {in_i, in_q} = 32'h0000_0000;
    out_ready = 1'b0;
  end
  always @(posedge core_clk)
  begin
    took <= in_valid && in_ready;
    if (rst_n && out_valid && out_ready) rx.push_back({out0_i, out0_q, out1_i, out1_q});
  end
  // a sample is held until taken; idle lines toggle so stale data never looks valid
  always @(negedge core_clk)
  begin
    out_ready <= !stall;
    if (!rst_n) in_valid <= 1'b0;
    else if (!in_valid || took)
    begin
      in_valid <= tx.size() > 0;
      if (tx.size() > 0) {in_i, in_q} <= tx.pop_front();
      else {in_i, in_q} <= ~{in_i, in_q};
    end
  end
endmodule

// ### tb/tb_ddc_nco_mixer_translation.sv
// self-checking testbench of the frequency translation stage
`timescale 1ns/1ps
module tb_ddc_nco_mixer_translation;
  import ddc_pkg::*;
  localparam int P = DDC_OSC_PEAK;
  localparam int X = 32'h4000;
  logic core_clk = 1'b0;
  logic rst_n, reg_wr, reg_rd, frame_sync, stall, in_valid, in_ready, out_valid, out_ready;
  ddc_addr_t reg_addr;
  ddc_byte_t reg_wdata, reg_rdata;
  ddc_sample_t in_i, in_q, out0_i, out0_q, out1_i, out1_q;
  int fail_count = 0;
  int n_compared = 0;
  int c4[4] = '{P, 0, -P, 0};

  always #25 core_clk = ~core_clk;

  ddc_translate dut (.*);
  ddc_stream_model src (.*);

  //////////////////////////////////////////////////////////////////////////////
  // mixer rounding may floor before or after negation, hence the tolerance
  task automatic cmp(string what, ddc_sample_t e, ddc_sample_t g, int tol);
    int d;
    d = int'(g) - int'(e);
    n_compared++;
    if ($isunknown(g) || d > tol || d < -tol)
    begin
      fail_count++;
      $display("unexpected %s expected %0d seen %0d", what, e, g);
    end
  endtask
  function automatic logic [31:0] rmix(int x, int c, int s);
    return {16'((x * c) >>> 16), 16'((-(x * s)) >>> 16)};
  endfunction
  task automatic chk4(logic [63:0] r, logic [31:0] e0, logic [31:0] e1, int tol);
    cmp("out0_i", e0[31:16], r[63:48], tol);
    cmp("out0_q", e0[15:0], r[47:32], tol);
    cmp("out1_i", e1[31:16], r[31:16], tol);
    cmp("out1_q", e1[15:0], r[15:0], tol);
  endtask
  task automatic wr(ddc_addr_t a, ddc_byte_t d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rdc(ddc_addr_t a, ddc_byte_t e);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    cmp("register", {8'h00, e}, {8'h00, reg_rdata}, 0);
  endtask
  task automatic wr6(ddc_addr_t a, logic [47:0] w);
    for (int k = 0; k < DDC_WORD_BYTES; k++) wr(a + 12'(k), w[8 * k +: 8]);
  endtask
  task automatic stream(int n, int x);
    repeat (n) src.tx.push_back({16'(x), 16'(x)});
    for (int t = 0; t < 200 && src.rx.size() < n; t++) @(negedge core_clk);
    cmp("result count", 16'(n), 16'(src.rx.size()), 0);
  endtask
  task automatic q4;
    stream(4, X);
    for (int k = 0; k < 4; k++)
      chk4(src.rx.pop_front(), rmix(X, c4[k], c4[(k + 3) % 4]), rmix(X, 0, c4[(k % 2) * 2]), 2);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    ddc_addr_t regs[7] = '{DDC_ADDR_PAIR_SEL, DDC_ADDR_FSYNC0, DDC_ADDR_FSYNC1, DDC_ADDR_SYNC_CTRL,
      DDC_ADDR_CH0_CTRL, DDC_ADDR_CH1_CTRL, 12'h200};
    foreach (regs[k]) rdc(regs[k], DDC_RST_BYTE);
    wr(12'h200, 8'hA5);
    rdc(12'h200, 8'h00);
    wr(DDC_ADDR_CH0_CTRL, 8'h90);
    wr(DDC_ADDR_PAIR_SEL, 8'h01);
    rdc(DDC_ADDR_PAIR_SEL, 8'h01);
    rdc(DDC_ADDR_CH0_CTRL, 8'h00);
    wr(DDC_ADDR_CH0_CTRL, 8'h90);
    rdc(DDC_ADDR_CH0_CTRL, 8'h90);
    wr(DDC_ADDR_FSYNC1, 8'h5A);
    rdc(DDC_ADDR_FSYNC1, 8'h5A);
  endtask
  task automatic t_zif;
    wr(DDC_ADDR_CH0_CTRL, 8'h10);
    wr(DDC_ADDR_CH1_CTRL, 8'h90);
    stream(2, -X);
    repeat (2) chk4(src.rx.pop_front(), {16'(-X), 16'(-X)}, {16'(-X), 16'(-X)}, 0);
  endtask
  task automatic t_mix;
    int v;
    wr(DDC_ADDR_CH0_CTRL, 8'h00);
    wr(DDC_ADDR_CH1_CTRL, 8'h80);
    v = (((X * P) >>> 15) * DDC_CPLX_SCALE) >>> 15;
    stream(1, X);
    chk4(src.rx.pop_front(), rmix(X, P, 0), {16'(v), 16'(v)}, 2);
  endtask
  // quarter and half rate tuning; each sync follows a sample that moved the phase off zero
  task automatic t_quad;
    wr(DDC_ADDR_CH0_CTRL, 8'h00);
    wr(DDC_ADDR_CH1_CTRL, 8'h00);
    wr6(DDC_ADDR_CH0_CTRL + DDC_OFF_TUNING, 48'h4000_0000_0000);
    wr6(DDC_ADDR_CH1_CTRL + DDC_OFF_TUNING, 48'h8000_0000_0000);
    wr6(DDC_ADDR_CH0_CTRL + DDC_OFF_PHASE, DDC_RST_WORD);
    wr6(DDC_ADDR_CH1_CTRL + DDC_OFF_PHASE, 48'h4000_0000_0000);
    stream(1, X);
    src.rx.delete();
    wr(DDC_ADDR_SYNC_CTRL, 8'h10);
    wr(DDC_ADDR_SYNC_CTRL, 8'h00);
    q4;
    stream(1, X);
    src.rx.delete();
    wr(DDC_ADDR_FSYNC0, 8'h01);
    wr(DDC_ADDR_SYNC_CTRL, 8'h01);
    @(negedge core_clk);
    frame_sync = 1'b1;
    @(negedge core_clk);
    frame_sync = 1'b0;
    q4;
  endtask
  // quarter carrier is back at zero degrees: four samples since the last frame sync
  task automatic t_fs4;
    wr(DDC_ADDR_CH0_CTRL, 8'h20);
    wr(DDC_ADDR_CH1_CTRL, 8'h30);
    wr6(DDC_ADDR_CH1_CTRL + DDC_OFF_TUNING, DDC_RST_WORD);
    stream(4, X);
    for (int k = 0; k < 4; k++)
      chk4(src.rx.pop_front(), rmix(X, c4[k], c4[(k + 3) % 4]), rmix(DDC_TEST_LEVEL, 0, P), 2);
  endtask
  task automatic t_buf;
    wr(DDC_ADDR_CH0_CTRL, 8'h10);
    stall = 1'b1;
    repeat (2) @(negedge core_clk);
    for (int k = 1; k <= 3; k++) src.tx.push_back({16'(k), 16'(k)});
    repeat (8) @(negedge core_clk);
    cmp("in_ready", 16'h0000, {15'h0000, in_ready}, 0);
    cmp("delivered while stalled", 16'h0000, 16'(src.rx.size()), 0);
    stall = 1'b0;
    stream(0, 0);
    for (int t = 0; t < 50 && src.rx.size() < 3; t++) @(negedge core_clk);
    cmp("result count", 16'h0003, 16'(src.rx.size()), 0);
    for (int k = 1; k <= 3 && src.rx.size() > 0; k++) cmp("out0_i", 16'(k), src.rx.pop_front() >> 48, 0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame_sync = 1'b0;
    stall = 1'b0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    t_regs;
    t_zif;
    t_mix;
    t_quad;
    t_fs4;
    t_buf;
    conclude;
  end
  // about 200 cycles expected; allow twenty thousand
  initial
  begin
    #1000000;
    fail_count++;
    conclude;
  end
endmodule
